// >>> verification/dual_quad_dtr_read_path_tb.sv
// self-checking bench for the dual and quad double-rate read path
// assumes host_model drives the pins; this bench stands in for the array
`timescale 1ns/10ps
module dual_quad_dtr_read_path_tb
    import ddr_read_pkg::*;
;
    localparam int ADDR_W = ARRAY_ADDR_W;
    localparam logic [7:0] OPS [4] = '{OP_DUAL_READ, OP_DUAL_READ_WIDE,
        OP_QUAD_READ, OP_QUAD_READ_WIDE};
    logic clock = 1'b0;
    logic reset = 1'b1;
    pins_in_t pins_in;
    pins_out_t pins_out;
    logic write_in_progress = 1'b0;
    logic quad_enable = 1'b1;
    logic extended_address_enable = 1'b0;
    logic [3:0] dual_dummy_clocks = 4'h0;
    logic [3:0] quad_dummy_clocks = 4'h0;
    mem_req_t mem_req;
    logic mem_rsp_valid = 1'b0;
    logic [7:0] mem_rsp_data = 8'h00;
    logic mem_rsp_ready;
    logic continuous_read_mode;
    int failures = 0;
    int cmp_count = 0;
    int lat = 0; // clocks left before the array answers
    logic [31:0] req_addr;
    logic [7:0] last_op; // opcode that a continuous frame reuses
    initial forever #25 clock = ~clock;
    dual_quad_dtr_read_path #(.ADDR_W(ADDR_W)) dual_quad_dtr_read_path_inst (
        .clock, .reset, .pins_in, .pins_out, .write_in_progress,
        .quad_enable, .extended_address_enable, .dual_dummy_clocks,
        .quad_dummy_clocks, .mem_req, .mem_rsp_valid, .mem_rsp_data,
        .mem_rsp_ready, .continuous_read_mode);
    host_model host_model_inst (.clock, .dev(pins_out), .pins(pins_in));
    // array content is a fold of the address, so every byte is checkable
    function automatic logic [7:0] exp_byte(input logic [31:0] x);
        return x[7:0] ^ x[15:8] ^ x[23:16] ^ {6'h0, x[25:24]};
    endfunction : exp_byte
    // array stand-in: one answer per request after one to three clocks
    always @(posedge clock) begin
        mem_rsp_valid <= 1'b0;
        if (mem_req.valid) begin
            req_addr = mem_req.addr;
            lat = $urandom_range(3, 1);
        end else if (lat > 0) begin
            lat = lat - 1;
            mem_rsp_valid <= (lat == 0);
            mem_rsp_data <= exp_byte(req_addr);
        end
    end
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    // one frame; skip reuses the last opcode, ok=0 expects silence
    task automatic run(logic [7:0] op, bit skip, logic [31:0] a,
        logic [7:0] mode, int nb, logic [3:0] dc, bit ok);
        int ab;
        int dum;
        if (skip) op = last_op;
        last_op = op;
        ab = (!op[0] || extended_address_enable) ? 32 : 24;
        if (ab == 24) a[31:24] = 8'h00;
        dum = dc ? dc : op[6] ? QUAD_DUMMY_DEFAULT : DUAL_DUMMY_DEFAULT;
        dual_dummy_clocks <= dc;
        quad_dummy_clocks <= dc;
        host_model_inst.frame(op, op[6], skip, ab, a, mode, dum, nb);
        if (!ok) check("silent", 0, host_model_inst.seen_oe);
        if (!ok) return;
        check("lanes", op[6] ? 4'hf : 4'h3, host_model_inst.seen_oe);
        for (int i = 0; i < nb; i++)
            check("data", exp_byte(a + i), host_model_inst.got[i]);
        check("cont", mode[7:4] == 4'ha, continuous_read_mode);
    endtask : run
    initial begin
        void'($urandom(32'h2c15));
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        run(OP_DUAL_READ_WIDE, 0, 32'h03ff_fffe, 8'h00, 4, 4'h0, 1);
        for (int i = 0; i < 8; i++) begin
            extended_address_enable <= i[0];
            @(posedge clock);
            run(OPS[i / 2], 0, $urandom, {4'($urandom_range(9, 0)), 4'h5},
                $urandom_range(5, 1), i[1] ? 4'($urandom_range(8, 3)) : 4'h0,
                1);
        end
        for (int q = 0; q < 2; q++) begin
            run(OPS[2 * q], 0, $urandom, 8'ha5, 3, 4'h0, 1);
            run(8'h00, 1, $urandom, 8'ha0, 2, 4'h0, 1);
            run(8'h00, 1, $urandom, 8'h5a, 2, 4'h0, 1);
        end
        write_in_progress <= 1'b1;
        run(OP_QUAD_READ, 0, $urandom, 8'h00, 2, 4'h0, 0);
        write_in_progress <= 1'b0;
        quad_enable <= 1'b0;
        run(OP_QUAD_READ_WIDE, 0, $urandom, 8'h00, 2, 4'h0, 0);
        quad_enable <= 1'b1;
        run(8'h03, 0, $urandom, 8'h00, 2, 4'h0, 0);
        run(OP_DUAL_READ, 0, $urandom, 8'h00, 2, 4'h0, 1);
        final_report;
    end
    // hang guard
    initial begin
        repeat (60000) @(posedge clock);
        failures++;
        $display("MISMATCH run expected end seen timeout");
        final_report;
    end
endmodule : dual_quad_dtr_read_path_tb
bind dual_quad_dtr_read_path read_path_monitor #(.ADDR_W(ADDR_W))
    read_path_monitor_inst (.clock, .reset, .pins_in, .pins_out,
    .write_in_progress, .quad_enable, .mem_req, .mem_rsp_valid,
    .mem_rsp_ready, .continuous_read_mode);

// >>> verification/host_model.sv
// host side of the serial link: select, serial clock and data lines
// assumes tasks are called at a clock edge; half period is four clocks
`timescale 1ns/10ps
module host_model
    import ddr_read_pkg::*;
(
    input wire logic clock,
    input wire pins_out_t dev,
    output pins_in_t pins
);
    logic cs_r = 1'b1; // select idles high
    logic sclk_r = 1'b0; // serial clock parks low outside frames
    logic [3:0] hio = 4'h0; // host drive on the lines
    logic [3:0] smp; // line value seen just before an edge
    logic [3:0] seen_oe = 4'h0; // all enables seen in the frame
    logic [7:0] got[$]; // bytes read back
    // device drive wins wherever its enable is up
    assign pins = '{cs_r, sclk_r, (dev.oe & dev.io) | (~dev.oe & hio)};
    // gather the device enables while selected
    always @(posedge clock) begin
        if (!cs_r) seen_oe <= seen_oe | dev.oe;
    end
    // lines set two clocks ahead of the edge and held two after it
    task automatic step(input logic [3:0] v);
        hio <= v;
        repeat (2) @(posedge clock);
        smp = pins.io;
        sclk_r <= ~sclk_r;
        repeat (2) @(posedge clock);
    endtask : step
    task automatic frame(input logic [7:0] op, input bit q, input bit skip,
        input int ab, input logic [31:0] a, input logic [7:0] mode,
        input int dum, input int nb);
        int l;
        logic [3:0] m;
        logic [7:0] b;
        l = q ? 4 : 2;
        m = 4'((1 << l) - 1);
        got = {};
        seen_oe = 4'h0;
        cs_r <= 1'b0;
        repeat (2) @(posedge clock);
        for (int i = 7; i >= 0 && !skip; i--) begin
            step({3'h0, op[i]});
            step({3'h0, op[i]});
        end
        for (int i = ab - l; i >= 0; i -= l) begin
            step(4'(a >> i) & m);
        end
        // mode byte first, then the host keeps driving the lines, toggled each step
        for (int i = 0; i < 2 * dum; i++) begin
            if (i < 8 / l) step(4'(mode >> (8 - l * (i + 1))) & m);
            else step(~hio);
        end
        for (int k = 0; k < nb; k++) begin
            b = 8'h00;
            for (int j = 0; j < 8 / l; j++) begin
                step(~hio);
                b = (b << l) | 8'(smp & m);
            end
            got.push_back(b);
        end
        cs_r <= 1'b1;
        repeat (4) @(posedge clock);
    endtask : frame
endmodule : host_model

// >>> verification/read_path_monitor.sv
// port assertions for the dual/quad double-rate read path
// assumes it is bound into that module: one clock, sync reset
`timescale 1ns/10ps
module read_path_monitor
    import ddr_read_pkg::*;
#(
    parameter int ADDR_W = ARRAY_ADDR_W
) (
    input wire logic clock,
    input wire logic reset,
    input wire pins_in_t pins_in,
    input wire pins_out_t pins_out,
    input wire logic write_in_progress,
    input wire logic quad_enable,
    input wire mem_req_t mem_req,
    input wire logic mem_rsp_valid,
    input wire logic mem_rsp_ready,
    input wire logic continuous_read_mode
);
    logic [ADDR_W-1:0] last_r; // last requested byte address
    logic seen_r; // a request was made in this frame
    logic pend_r; // a request still waits for its answer
    logic blk_r; // frame opened while the array was busy
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // helper state; select high closes a frame
    always_ff @(posedge clock) begin
        seen_r <= !reset && !pins_in.cs_n && (seen_r || mem_req.valid);
        blk_r <= !reset && !pins_in.cs_n
            && (blk_r || ($fell(pins_in.cs_n) && write_in_progress));
        pend_r <= !reset && (mem_req.valid || (pend_r && !mem_rsp_valid));
        if (mem_req.valid) begin
            last_r <= mem_req.addr[ADDR_W-1:0];
        end
    end
    lane_shape_a: assert property (pins_out.oe inside {4'h0, 4'h3, 4'hf})
        else $error("enable pattern illegal");
    select_float_a: assert property (pins_in.cs_n |=> pins_out.oe == 4'h0)
        else $error("lines driven while deselected");
    addr_step_a: assert property (mem_req.valid && seen_r && !pins_in.cs_n
        |-> mem_req.addr[ADDR_W-1:0] == last_r + 1'b1) else $error("bad step");
    one_request_a: assert property (mem_req.valid |-> !pend_r && mem_rsp_ready)
        else $error("request overlaps");
    busy_quiet_a: assert property (blk_r |-> pins_out.oe == 4'h0)
        else $error("read served while busy");
    mode_hold_a: assert property ($past(pins_in.cs_n, 2) && $past(pins_in.cs_n)
        |-> $stable(continuous_read_mode)) else $error("mode moved idle");
    edge_paced_a: assert property ($changed(pins_out.io)
        && |pins_out.oe |-> $past(pins_in.sclk) != $past(pins_in.sclk, 2))
        else $error("off edge");
    quad_gate_a: assert property (pins_out.oe == 4'hf |-> quad_enable)
        else $error("quad data without enable");
    cover property (continuous_read_mode ##1 !continuous_read_mode);
    cover property (pins_out.oe == 4'hf);
    cover property (mem_req.valid && seen_r && mem_req.addr == 32'h0);
endmodule : read_path_monitor

// >>> verilog/byte_fifo.sv
// first-in first-out buffer with valid/ready on both sides and a flush
// assumes one clock; flush beats a push in the same cycle
`timescale 1ns/10ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);

    // pointers wrap by width, so only powers of two are served
    if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
        $error("byte_fifo DEPTH must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [PTR_W-1:0] wptr; // next slot to write
        logic [PTR_W-1:0] rptr; // oldest slot
        logic [PTR_W:0] count; // words held
        logic full; // registered so ready leaves a flop
        logic empty;
    } fifo_state_t;

    fifo_state_t st_r;
    fifo_state_t st_nxt;
    logic [WIDTH-1:0] mem [DEPTH]; // storage
    logic push;
    logic pop;

    assign push = in_valid & ~st_r.full & ~flush;
    assign pop = out_ready & ~st_r.empty & ~flush;

    // pointer and occupancy update
    always_comb begin : next_state
        st_nxt = st_r;
        if (flush) begin
            st_nxt = '0;
            st_nxt.empty = 1'b1;
        end else begin
            if (push) begin
                st_nxt.wptr = st_r.wptr + 1'b1;
            end
            if (pop) begin
                st_nxt.rptr = st_r.rptr + 1'b1;
            end
            if (push && !pop) begin
                st_nxt.count = st_r.count + 1'b1;
            end else if (pop && !push) begin
                st_nxt.count = st_r.count - 1'b1;
            end
            st_nxt.full = (st_nxt.count == (PTR_W + 1)'(DEPTH));
            st_nxt.empty = (st_nxt.count == '0);
        end
    end

    always_ff @(posedge clock) begin : regs
        if (reset) begin
            st_r <= '0;
            st_r.empty <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // storage is not reset, contents are only read when counted
    always_ff @(posedge clock) begin : store
        if (push) begin
            mem[st_r.wptr] <= in_data;
        end
    end

    assign in_ready = ~st_r.full;
    assign out_valid = ~st_r.empty;
    assign out_data = mem[st_r.rptr];
endmodule : byte_fifo

// >>> verilog/ddr_read_pkg.sv
// constants, opcodes and carrier types of the dual/quad double-rate read path
// assumes one 20 MHz clock that samples the serial pins as plain inputs
package ddr_read_pkg;
    // opcodes
    localparam logic [7:0] OP_DUAL_READ = 8'hbd;
    localparam logic [7:0] OP_DUAL_READ_WIDE = 8'hbe;
    localparam logic [7:0] OP_QUAD_READ = 8'hed;
    localparam logic [7:0] OP_QUAD_READ_WIDE = 8'hee;
    // upper nibble of the mode byte that keeps continuous mode
    localparam logic [3:0] CONT_MODE_NIBBLE = 4'ha;
    // dummy clocks used when the config port reads zero
    localparam int DUAL_DUMMY_DEFAULT = 4;
    localparam int QUAD_DUMMY_DEFAULT = 6;
    localparam int DUMMY_MAX = 15;
    // framing
    localparam int OPCODE_BITS = 8;
    localparam int SHORT_ADDR_BITS = 24;
    localparam int WIDE_ADDR_BITS = 32;
    localparam int BYTE_BITS = 8;
    localparam int DUAL_LANES = 2;
    localparam int QUAD_LANES = 4;
    localparam int EDGES_PER_CLOCK = 2;
    // 64 Mbyte array and prefetch depth
    localparam int ARRAY_ADDR_W = 26;
    localparam int FIFO_DEPTH = 16;
    // byte driven when the prefetch has not caught up
    localparam logic [7:0] UNDERRUN_BYTE = 8'hff;

    // serial pins as sampled
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic [3:0] io;
    } pins_in_t;

    // data line drive, oe high while driving
    typedef struct packed {
        logic [3:0] io;
        logic [3:0] oe;
    } pins_out_t;

    // byte read request towards the array
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } mem_req_t;
endpackage : ddr_read_pkg

// >>> verilog/dual_quad_dtr_read_path.sv
// device side of the dual and quad double-rate reads in single-line
// command mode: opcode, address, dummy/mode, data, continuous mode
// assumes serial pins sampled by a clock several times faster than sclk,
// and an array port answering one byte request at a time
`timescale 1ns/10ps
module dual_quad_dtr_read_path
    import ddr_read_pkg::*;
#(
    parameter int ADDR_W = ARRAY_ADDR_W,
    parameter int DEPTH = FIFO_DEPTH,
    parameter int DUAL_DUMMY = DUAL_DUMMY_DEFAULT,
    parameter int QUAD_DUMMY = QUAD_DUMMY_DEFAULT
) (
    input wire logic clock,
    input wire logic reset,
    input wire pins_in_t pins_in,
    output pins_out_t pins_out,
    input wire logic write_in_progress,
    input wire logic quad_enable,
    input wire logic extended_address_enable,
    input wire logic [3:0] dual_dummy_clocks,
    input wire logic [3:0] quad_dummy_clocks,
    output mem_req_t mem_req,
    input wire logic mem_rsp_valid,
    input wire logic [7:0] mem_rsp_data,
    output logic mem_rsp_ready,
    output logic continuous_read_mode
);
    // elaboration checks
    if (ADDR_W < SHORT_ADDR_BITS || ADDR_W > WIDE_ADDR_BITS) begin : g_bad_aw
        $error("ADDR_W must lie between 24 and 32");
    end
    if (DUAL_DUMMY < 1 || DUAL_DUMMY > DUMMY_MAX) begin : g_bad_dd
        $error("DUAL_DUMMY must lie between 1 and 15");
    end
    if (QUAD_DUMMY < 1 || QUAD_DUMMY > DUMMY_MAX) begin : g_bad_qd
        $error("QUAD_DUMMY must lie between 1 and 15");
    end

    // phases of one selected frame
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_OPCODE,
        PH_ADDR,
        PH_DUMMY,
        PH_DATA,
        PH_IGNORE
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic cont; // continuous read mode
        logic quad; // frame uses four lines
        logic wide; // frame uses 4-byte address
        logic [5:0] cnt; // edges or bits in this phase
        logic [31:0] sh; // opcode and address shifter
        logic [7:0] mode; // mode byte being collected
        logic [7:0] dbyte; // byte on the lines
        logic [1:0] chunk; // part of dbyte now driven
        logic [ADDR_W-1:0] fetch; // next array byte to prefetch
        logic fetch_on; // prefetch allowed
        logic pend; // one request outstanding
        logic drop; // outstanding answer is stale
        mem_req_t req;
        pins_out_t pins;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic sclk_rise; // sampled sclk went high
    logic sclk_fall; // sampled sclk went low
    logic fifo_in_ready;
    logic fifo_valid;
    logic fifo_pop;
    logic [7:0] fifo_data;
    logic fifo_push;

    // shift in one edge worth of bits
    function automatic logic [31:0] shift_in(logic [31:0] sh,
                                             logic [3:0] io, logic quad);
        if (quad) begin
            return {sh[27:0], io};
        end
        return {sh[29:0], io[1:0]};
    endfunction : shift_in

    // edges that carry the address
    function automatic logic [5:0] addr_edges(logic quad, logic wide);
        int bits;
        bits = wide ? WIDE_ADDR_BITS : SHORT_ADDR_BITS;
        return 6'(bits / (quad ? QUAD_LANES : DUAL_LANES));
    endfunction : addr_edges

    // edges that carry the mode byte
    function automatic logic [5:0] mode_edges(logic quad);
        return 6'(BYTE_BITS / (quad ? QUAD_LANES : DUAL_LANES));
    endfunction : mode_edges

    // dummy edges, a zero config selects the default
    function automatic logic [5:0] dummy_edges(logic quad,
                                               logic [3:0] dcfg,
                                               logic [3:0] qcfg);
        int clocks;
        if (quad) begin
            clocks = (qcfg == 4'h0) ? QUAD_DUMMY : int'(qcfg);
        end else begin
            clocks = (dcfg == 4'h0) ? DUAL_DUMMY : int'(dcfg);
        end
        return 6'(clocks * EDGES_PER_CLOCK);
    endfunction : dummy_edges

    // bits of a byte for one edge, high bits first
    function automatic logic [3:0] chunk_of(logic [7:0] b, logic [1:0] idx,
                                            logic quad);
        if (quad) begin
            return idx[0] ? b[3:0] : b[7:4];
        end
        unique case (idx)
            2'h0: return {2'h0, b[7:6]};
            2'h1: return {2'h0, b[5:4]};
            2'h2: return {2'h0, b[3:2]};
            2'h3: return {2'h0, b[1:0]};
        endcase
    endfunction : chunk_of

    // lanes driven in the data phase
    function automatic logic [3:0] lanes_oe(logic quad);
        return quad ? 4'hf : 4'h3;
    endfunction : lanes_oe

    // last chunk index of a byte
    function automatic logic [1:0] last_chunk(logic quad);
        return quad ? 2'h1 : 2'h3;
    endfunction : last_chunk

    sclk_edge_detect u_edge (
        .clock(clock),
        .reset(reset),
        .level(pins_in.sclk),
        .rise(sclk_rise),
        .fall(sclk_fall)
    );

    // prefetch buffer between the array and the output shifter; the
    // request logic waits on its ready, so a slow drain stalls the array
    byte_fifo #(
        .WIDTH(BYTE_BITS),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock(clock),
        .reset(reset),
        .flush(pins_in.cs_n),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(mem_rsp_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // answers to a request made before an abort are thrown away
    assign fifo_push = mem_rsp_valid & ~st_r.drop & ~pins_in.cs_n;

    // frame sequencer and prefetch
    always_comb begin : next_state
        logic [31:0] sh;
        logic [7:0] nbyte;
        sh = '0;
        nbyte = '0;
        st_nxt = st_r;
        st_nxt.req.valid = 1'b0;
        fifo_pop = 1'b0;
        if (pins_in.cs_n) begin
            // abort at any point; cont is kept
            st_nxt.phase = PH_IDLE;
            st_nxt.cnt = '0;
            st_nxt.chunk = '0;
            st_nxt.fetch_on = 1'b0;
            st_nxt.pins = '0;
        end else begin
            unique case (st_r.phase)
                PH_IDLE: begin
                    st_nxt.cnt = '0;
                    st_nxt.sh = '0;
                    if (write_in_progress) begin
                        st_nxt.phase = PH_IGNORE;
                    end else if (st_r.cont) begin
                        // no opcode, reuse the last frame's shape
                        st_nxt.phase = PH_ADDR;
                    end else begin
                        st_nxt.phase = PH_OPCODE;
                    end
                end
                PH_OPCODE: begin
                    if (sclk_rise) begin
                        // opcode one bit per rising edge on line 0
                        sh = {st_r.sh[30:0], pins_in.io[0]};
                        st_nxt.sh = sh;
                        st_nxt.cnt = st_r.cnt + 6'h01;
                        if (st_r.cnt == 6'(OPCODE_BITS - 1)) begin
                            st_nxt.cnt = '0;
                            st_nxt.sh = '0;
                            st_nxt.phase = PH_ADDR;
                            case (sh[7:0])
                                OP_DUAL_READ: begin
                                    st_nxt.quad = 1'b0;
                                    st_nxt.wide = extended_address_enable;
                                end
                                OP_DUAL_READ_WIDE: begin
                                    st_nxt.quad = 1'b0;
                                    st_nxt.wide = 1'b1;
                                end
                                OP_QUAD_READ: begin
                                    st_nxt.quad = 1'b1;
                                    st_nxt.wide = extended_address_enable;
                                end
                                OP_QUAD_READ_WIDE: begin
                                    st_nxt.quad = 1'b1;
                                    st_nxt.wide = 1'b1;
                                end
                                default: begin
                                    // not a read of this block
                                    st_nxt.phase = PH_IGNORE;
                                end
                            endcase
                            // quad lines are not ours without quad enable
                            if ((sh[7:0] == OP_QUAD_READ ||
                                 sh[7:0] == OP_QUAD_READ_WIDE) &&
                                !quad_enable) begin
                                st_nxt.phase = PH_IGNORE;
                            end
                            if (write_in_progress) begin
                                st_nxt.phase = PH_IGNORE;
                            end
                        end
                    end
                end
                PH_ADDR: begin
                    // both edges, starting at a rising one
                    if (sclk_rise || (sclk_fall && st_r.cnt != '0)) begin
                        sh = shift_in(st_r.sh, pins_in.io, st_r.quad);
                        st_nxt.sh = sh;
                        st_nxt.cnt = st_r.cnt + 6'h01;
                        if (st_r.cnt ==
                            addr_edges(st_r.quad, st_r.wide) - 6'h01) begin
                            // start anywhere in the array
                            st_nxt.fetch = sh[ADDR_W-1:0];
                            st_nxt.fetch_on = 1'b1;
                            st_nxt.phase = PH_DUMMY;
                            st_nxt.cnt = '0;
                            st_nxt.mode = '0;
                        end
                    end
                end
                PH_DUMMY: begin
                    if (sclk_rise || (sclk_fall && st_r.cnt != '0)) begin
                        st_nxt.cnt = st_r.cnt + 6'h01;
                        // mode byte leads the dummy clocks
                        if (st_r.cnt < mode_edges(st_r.quad)) begin
                            sh = shift_in({24'h0, st_r.mode}, pins_in.io,
                                          st_r.quad);
                            st_nxt.mode = sh[7:0];
                            if (st_r.cnt == mode_edges(st_r.quad) - 6'h01)
                            begin
                                // nibble A stays or enters, else leaves
                                st_nxt.cont = (sh[7:4] == CONT_MODE_NIBBLE);
                            end
                        end
                        if (st_r.cnt == dummy_edges(st_r.quad,
                                                    dual_dummy_clocks,
                                                    quad_dummy_clocks)
                                        - 6'h01) begin
                            // first data leaves on the last dummy edge
                            nbyte = fifo_valid ? fifo_data : UNDERRUN_BYTE;
                            fifo_pop = fifo_valid;
                            st_nxt.phase = PH_DATA;
                            st_nxt.dbyte = nbyte;
                            st_nxt.chunk = '0;
                            st_nxt.pins.io = chunk_of(nbyte, 2'h0, st_r.quad);
                            st_nxt.pins.oe = lanes_oe(st_r.quad);
                        end
                    end
                end
                PH_DATA: begin
                    // a new chunk on every edge until select rises
                    if (sclk_rise || sclk_fall) begin
                        if (st_r.chunk == last_chunk(st_r.quad)) begin
                            nbyte = fifo_valid ? fifo_data : UNDERRUN_BYTE;
                            fifo_pop = fifo_valid;
                            st_nxt.dbyte = nbyte;
                            st_nxt.chunk = '0;
                            st_nxt.pins.io = chunk_of(nbyte, 2'h0,
                                                      st_r.quad);
                        end else begin
                            st_nxt.chunk = st_r.chunk + 2'h1;
                            st_nxt.pins.io = chunk_of(st_r.dbyte,
                                                      st_r.chunk + 2'h1,
                                                      st_r.quad);
                        end
                    end
                end
                PH_IGNORE: begin
                    // lines stay released until select rises
                    st_nxt.pins = '0;
                end
            endcase
        end

        // array answers; a late answer after an abort is marked stale
        if (mem_rsp_valid) begin
            st_nxt.pend = 1'b0;
            st_nxt.drop = 1'b0;
        end else if (pins_in.cs_n && st_r.pend) begin
            st_nxt.drop = 1'b1;
        end

        // one request at a time, only while the buffer has room
        if (!pins_in.cs_n && st_r.fetch_on && !st_r.pend &&
            fifo_in_ready) begin
            st_nxt.req.valid = 1'b1;
            st_nxt.req.addr = 32'(st_r.fetch);
            st_nxt.fetch = st_r.fetch + 1'b1;
            st_nxt.pend = 1'b1;
        end
    end

    // state register; reset leaves idle, lines released, not continuous
    always_ff @(posedge clock) begin : regs
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pins_out = st_r.pins;
    assign mem_req = st_r.req;
    assign mem_rsp_ready = fifo_in_ready;
    assign continuous_read_mode = st_r.cont;
endmodule : dual_quad_dtr_read_path

// >>> verilog/sclk_edge_detect.sv
// edge finder for the sampled serial clock
// assumes the level is already synchronous to clock
`timescale 1ns/10ps
module sclk_edge_detect (
    input wire logic clock,
    input wire logic reset,
    input wire logic level,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic prev; // level seen one cycle ago
    } edge_state_t;

    edge_state_t st_r;
    edge_state_t st_nxt;

    // remember the last level
    always_comb begin : next_state
        st_nxt = st_r;
        st_nxt.prev = level;
    end

    always_ff @(posedge clock) begin : regs
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // one-cycle pulses on each transition
    assign rise = level & ~st_r.prev;
    assign fall = ~level & st_r.prev;
endmodule : sclk_edge_detect
